// file: irc_pkg.sv
package irc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'h40;
  localparam logic [7:0] IDX_CTRL_TWO = 8'h41;
  localparam logic [7:0] IDX_CTRL_THREE = 8'h42;
  localparam logic [7:0] IDX_STATUS_ONE = 8'h43;
  localparam logic [7:0] IDX_STATUS_TWO = 8'h44;
  localparam logic [7:0] IDX_DATA_BUF = 8'h45;
  localparam logic [7:0] IDX_BAUD_SEL = 8'h46;
  localparam logic [7:0] IDX_IR_CTRL = 8'h47;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_STATUS_ONE = 8'hc0;
  // Implemented-bit masks, other bits read as zero
  localparam logic [7:0] MASK_CTRL_ONE = 8'hdf;
  localparam logic [7:0] MASK_BAUD_SEL = 8'hb7;
  localparam logic [7:0] MASK_IR_CTRL = 8'h07;
  localparam logic [7:0] MASK_STATUS_TWO = 8'h03;
  localparam logic [5:0] RST_C3_LOW = 6'h00;
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int IR_EN_BIT = 0;
  localparam int IR_SEL_LO = 1;
  localparam int IR_SEL_HI = 2;
  localparam int BAUD_SRC_BIT = 7;
  localparam int SCP_LSB = 4;
  localparam int SCR_LSB = 0;
  typedef enum logic [1:0] {
    PW_3_16 = 2'b00,
    PW_1_16 = 2'b01,
    PW_1_32 = 2'b10,
    PW_RSVD = 2'b11
  } irc_width_type;
  // Pulse lengths in ticks of the selected reference
  localparam logic [1:0] LEN_3_16 = 2'h3;
  localparam logic [1:0] LEN_SHORT = 2'h1;
  localparam logic [3:0] BIT_LAST_PHASE = 4'hf;
  localparam logic [3:0] DEC_HALF = 4'h7;
  localparam logic [3:0] DEC_LAST = 4'hf;
  // Prescaler divisors for codes 0..3
  localparam logic [3:0] PD_0 = 4'h1;
  localparam logic [3:0] PD_1 = 4'h3;
  localparam logic [3:0] PD_2 = 4'h4;
  localparam logic [3:0] PD_3 = 4'hd;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_COUNT = 3'b010,
    DS_GUARD = 3'b100
  } irc_dec_state_type;
endpackage : irc_pkg

// file: irc_codec.sv
`timescale 1ns/1ps
// What this block does
// - With infrared on, each zero bit gives a narrow low pulse; ones leave pin high.
// - Pulse lasts 1/32, 1/16 or 3/16 bit, timed by the matching reference.
// - Back-to-back zeros give pulses one bit apart, each at its bit start.
// - Block generates reference ticks at 16 and 32 times the baud rate for the core.
// - Encoder may use either reference; decoder uses only the 16x one.
// - Decoder has a four-bit counter on the 16x reference, counting 0 to 15.
// - Pulse while idle starts counter and drives decoded output low at once.
// - Pulses seen while counter is 0 to 7 are ignored; output stays low.
// - Pulse after counter passes 7 restarts it from zero; output stays low.
// - At count 15 the output returns high and the counter halts.
// - Pulse shortly after count 15 is jitter; output stays high.
// - Infrared off passes pin levels straight through both ways.
// - Baud clock source selectable: bus clock or crystal reference.
// - Status one resets with its two top flags set, rest clear.
// - Control three keeps its top two bits over reset; low six clear.
// - Core sees plain NRZ framing whether infrared is on or off.
module irc_codec #(
  parameter int ADDR_W = 12,
  parameter int GUARD_TICKS = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic crystal_ref_clock,
  input wire logic sci_tx_stream,
  output logic decoded_rx_stream,
  output logic serial_tx_pin_o,
  output logic serial_tx_pin_oe,
  input wire logic serial_rx_pin,
  output logic baud_ref_clock_x16,
  output logic baud_ref_clock_x32,
  input wire logic [7:0] status_one_in,
  input wire logic [1:0] status_two_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_ninth_load,
  input wire logic rx_ninth_in,
  output logic [7:0] serial_control_one,
  output logic [7:0] serial_control_two,
  output logic [7:0] serial_control_three,
  output logic [7:0] tx_data,
  output logic tx_data_load,
  output logic rx_data_taken
);
  import irc_pkg::*;

  localparam int GW = $clog2(GUARD_TICKS + 1);
  localparam logic [GW-1:0] GUARD_INIT = GW'(GUARD_TICKS);

  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W too small for register map");
  end
  if (GUARD_TICKS < 1) begin : g_bad_guard
    $error("GUARD_TICKS must be at least 1");
  end

  // Returns {hit, index} for a byte address
  function automatic logic [8:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    reg_sel = {1'b0, idx};
    if (a[1:0] == 2'b00 && a[ADDR_W-1:2] == (ADDR_W-2)'(idx) &&
        idx >= IDX_CTRL_ONE && idx <= IDX_IR_CTRL) begin
      reg_sel = {1'b1, idx};
    end
  endfunction : reg_sel

  function automatic logic [3:0] pd_of(input logic [1:0] code);
    case (code)
      2'b00: pd_of = PD_0;
      2'b01: pd_of = PD_1;
      2'b10: pd_of = PD_2;
      default: pd_of = PD_3;
    endcase
  endfunction : pd_of

  // Register file and bus slave
  logic [7:0] c1_q, c1_d, c2_q, c2_d, s1_q, s1_d, s2_q, s2_d;
  logic [7:0] br_q, br_d, ir_q, ir_d, txd_q, txd_d;
  logic [5:0] c3lo_q, c3lo_d;
  logic [1:0] c3hi_q, c3hi_d;
  logic [31:0] rd_q, rd_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic wr_q, wr_d, load_q, load_d, take_q, take_d;
  logic [8:0] sel_a, sel_w;
  logic [7:0] rmux;
  logic ir_en;
  irc_width_type wsel;

  assign ir_en = ir_q[IR_EN_BIT];
  assign wsel = irc_width_type'({ir_q[IR_SEL_HI], ir_q[IR_SEL_LO]});

  always_comb begin
    sel_a = reg_sel(haddr);
    sel_w = reg_sel(a_q);
    c1_d = c1_q;
    c2_d = c2_q;
    c3lo_d = c3lo_q;
    c3hi_d = c3hi_q;
    br_d = br_q;
    ir_d = ir_q;
    txd_d = txd_q;
    load_d = 1'b0;
    take_d = 1'b0;
    s1_d = status_one_in;
    s2_d = {6'h00, status_two_in};
    wr_d = 1'b0;
    a_d = a_q;
    case (sel_a[7:0])
      IDX_CTRL_ONE: rmux = c1_q & MASK_CTRL_ONE;
      IDX_CTRL_TWO: rmux = c2_q;
      IDX_CTRL_THREE: rmux = {c3hi_q, c3lo_q};
      IDX_STATUS_ONE: rmux = s1_q;
      IDX_STATUS_TWO: rmux = s2_q & MASK_STATUS_TWO;
      IDX_DATA_BUF: rmux = rx_data_in;
      IDX_BAUD_SEL: rmux = br_q & MASK_BAUD_SEL;
      IDX_IR_CTRL: rmux = ir_q & MASK_IR_CTRL;
      default: rmux = 8'h00;
    endcase
    rd_d = 32'h0000_0000;
    if (hsel && htrans[1] && hready) begin
      a_d = haddr;
      wr_d = hwrite;
      if (!hwrite && sel_a[8]) begin
        rd_d = {24'h00_0000, rmux};
        take_d = (sel_a[7:0] == IDX_DATA_BUF);
      end
    end
    if (wr_q && sel_w[8]) begin
      case (sel_w[7:0])
        IDX_CTRL_ONE: c1_d = hwdata[7:0] & MASK_CTRL_ONE;
        IDX_CTRL_TWO: c2_d = hwdata[7:0];
        IDX_CTRL_THREE: begin
          c3lo_d = hwdata[5:0];
          c3hi_d[0] = hwdata[C3_TX_NINTH];
        end
        IDX_DATA_BUF: begin
          txd_d = hwdata[7:0];
          load_d = 1'b1;
        end
        IDX_BAUD_SEL: br_d = hwdata[7:0] & MASK_BAUD_SEL;
        IDX_IR_CTRL: ir_d = hwdata[7:0] & MASK_IR_CTRL;
        default: c1_d = c1_q;
      endcase
    end
    // Received ninth bit is loaded by the core only
    if (rx_ninth_load) begin
      c3hi_d[1] = rx_ninth_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_q <= RST_ZERO;
      c2_q <= RST_ZERO;
      c3lo_q <= RST_C3_LOW;
      s1_q <= RST_STATUS_ONE;
      s2_q <= RST_ZERO;
      br_q <= RST_ZERO;
      ir_q <= RST_ZERO;
      txd_q <= RST_ZERO;
      rd_q <= 32'h0000_0000;
      a_q <= '0;
      wr_q <= 1'b0;
      load_q <= 1'b0;
      take_q <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      c1_q <= c1_d;
      c2_q <= c2_d;
      c3lo_q <= c3lo_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      br_q <= br_d;
      ir_q <= ir_d;
      txd_q <= txd_d;
      rd_q <= rd_d;
      a_q <= a_d;
      wr_q <= wr_d;
      load_q <= load_d;
      take_q <= take_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk) begin
    c3hi_q <= c3hi_d;
  end

  assign hrdata = rd_q;
  assign serial_control_one = c1_q;
  assign serial_control_two = c2_q;
  assign serial_control_three = {c3hi_q, c3lo_q};
  assign tx_data = txd_q;
  assign tx_data_load = load_q;
  assign rx_data_taken = take_q;

  // Baud generator: wrap every PD*BD enables; 32x every 2, 16x every 4 wraps
  logic xs1_q, xs2_q, xs3_q;
  logic [3:0] pc_q, pc_d;
  logic [6:0] bc_q, bc_d, bd_max;
  logic [1:0] ph_q, ph_d;
  logic t16_q, t16_d, t32_q, t32_d, src_en, pre_tick;

  always_comb begin
    src_en = br_q[BAUD_SRC_BIT] ? (xs2_q & ~xs3_q) : 1'b1;
    bd_max = 7'((8'h01 << br_q[SCR_LSB +: 3]) - 8'h01);
    pc_d = pc_q;
    bc_d = bc_q;
    ph_d = ph_q;
    t16_d = 1'b0;
    t32_d = 1'b0;
    pre_tick = 1'b0;
    if (src_en) begin
      if (pc_q >= pd_of(br_q[SCP_LSB +: 2]) - 4'h1) begin
        pc_d = 4'h0;
        pre_tick = 1'b1;
      end else begin
        pc_d = pc_q + 4'h1;
      end
    end
    if (pre_tick) begin
      if (bc_q >= bd_max) begin
        bc_d = 7'h00;
        // baud is src/(64*PD*BD), so 32x is every second wrap
        t32_d = ph_q[0];
        t16_d = &ph_q;
        ph_d = ph_q + 2'h1;
      end else begin
        bc_d = bc_q + 7'h01;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xs3_q <= 1'b0;
      pc_q <= 4'h0;
      bc_q <= 7'h00;
      ph_q <= 2'h0;
      t16_q <= 1'b0;
      t32_q <= 1'b0;
    end else begin
      xs1_q <= crystal_ref_clock;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
      pc_q <= pc_d;
      bc_q <= bc_d;
      ph_q <= ph_d;
      t16_q <= t16_d;
      t32_q <= t32_d;
    end
  end

  assign baud_ref_clock_x16 = t16_q;
  assign baud_ref_clock_x32 = t32_q;

  // Transmit encoder
  logic prev_q, prev_d, pulse_q, pulse_d, txo_q, txo_d, txoe_q, txoe_d, bnd_q, bnd_d;
  logic [3:0] phase_q, phase_d;
  logic [1:0] pcnt_q, pcnt_d, plen;
  logic chg, start, wtick;

  always_comb begin
    chg = sci_tx_stream != prev_q;
    prev_d = sci_tx_stream;
    // restart phase at each stream edge
    phase_d = chg ? 4'h0 : (t16_q ? phase_q + 4'h1 : phase_q);
    // Last tick of a bit; the core moves its stream one cycle after it
    bnd_d = !chg && t16_q && phase_q == BIT_LAST_PHASE;
    // new zero, or next bit period still zero
    start = ir_en && !sci_tx_stream && (prev_q || (!chg && bnd_q));
    case (wsel)
      PW_1_16: plen = LEN_SHORT;
      PW_1_32: plen = LEN_SHORT;
      default: plen = LEN_3_16;
    endcase
    wtick = (wsel == PW_1_32) ? t32_q : t16_q;
    pulse_d = pulse_q && ir_en;
    pcnt_d = pcnt_q;
    if (start) begin
      pulse_d = 1'b1;
      pcnt_d = plen;
    end else if (pulse_q && wtick) begin
      pcnt_d = pcnt_q - 2'h1;
      if (pcnt_q == 2'h1) begin
        pulse_d = 1'b0;
      end
    end
    if (ir_en) begin
      txo_d = 1'b0;
      txoe_d = pulse_d;
    end else begin
      txo_d = sci_tx_stream;
      txoe_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q <= 1'b1;
      bnd_q <= 1'b0;
      phase_q <= 4'h0;
      pulse_q <= 1'b0;
      pcnt_q <= 2'h0;
      txo_q <= 1'b1;
      txoe_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      bnd_q <= bnd_d;
      phase_q <= phase_d;
      pulse_q <= pulse_d;
      pcnt_q <= pcnt_d;
      txo_q <= txo_d;
      txoe_q <= txoe_d;
    end
  end

  assign serial_tx_pin_o = txo_q;
  assign serial_tx_pin_oe = txoe_q;

  // Receive decoder
  irc_dec_state_type st_q, st_d;
  logic rs1_q, rs2_q, rs3_q, dec_q, dec_d, rxo_q, rxo_d, fall;
  logic [3:0] cnt_q, cnt_d;
  logic [GW-1:0] gd_q, gd_d;

  always_comb begin
    fall = rs3_q & ~rs2_q;
    st_d = st_q;
    cnt_d = cnt_q;
    gd_d = gd_q;
    dec_d = dec_q;
    case (st_q)
      DS_IDLE: begin
        if (fall && ir_en) begin
          st_d = DS_COUNT;
          cnt_d = 4'h0;
          dec_d = 1'b0;
        end
      end
      DS_COUNT: begin
        // restart past 7; ignore up to 7
        if (fall && cnt_q > DEC_HALF) begin
          cnt_d = 4'h0;
        end else if (t16_q) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == DEC_LAST - 4'h1) begin
            dec_d = 1'b1;
            st_d = DS_GUARD;
            gd_d = GUARD_INIT;
          end
        end
      end
      DS_GUARD: begin
        if (t16_q) begin
          gd_d = gd_q - GW'(1);
          if (gd_q == GW'(1)) begin
            st_d = DS_IDLE;
          end
        end
      end
      default: begin
        st_d = DS_IDLE;
        dec_d = 1'b1;
      end
    endcase
    if (!ir_en) begin
      st_d = DS_IDLE;
      dec_d = 1'b1;
    end
    rxo_d = ir_en ? dec_d : rs2_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      rs3_q <= 1'b1;
      st_q <= DS_IDLE;
      cnt_q <= 4'h0;
      gd_q <= '0;
      dec_q <= 1'b1;
      rxo_q <= 1'b1;
    end else begin
      rs1_q <= serial_rx_pin;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      st_q <= st_d;
      cnt_q <= cnt_d;
      gd_q <= gd_d;
      dec_q <= dec_d;
      rxo_q <= rxo_d;
    end
  end

  assign decoded_rx_stream = rxo_q;

endmodule : irc_codec

// file: irc_codec_properties.sv
`timescale 1ns/1ps
module irc_codec_properties
  import irc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic sci_tx_stream,
  input wire logic decoded_rx_stream,
  input wire logic serial_tx_pin_o,
  input wire logic serial_tx_pin_oe,
  input wire logic serial_rx_pin,
  input wire logic baud_ref_clock_x16,
  input wire logic baud_ref_clock_x32
);
  logic wr_q, wr_d, oe_q, pin_q, ir_on, ir_off;
  logic [2:0] ir_q, ir_d, st_q, st_d, w16_q, w16_d, w32_q, w32_d;
  logic [4:0] lo_q, lo_d, sf_q, sf_d;
  // Shadow of the enable, so the checker needs no internal probes
  always_comb begin
    wr_d = hsel && htrans[1] && hready && hwrite && haddr == ADDR_W'({IDX_IR_CTRL, 2'b00});
    ir_d = wr_q ? hwdata[2:0] : ir_q;
    st_d = (ir_d[0] != ir_q[0]) ? 3'h0 : st_q + 3'(st_q != 3'h7);
    w16_d = serial_tx_pin_oe ? (oe_q ? w16_q : 3'h0) + 3'(baud_ref_clock_x16) : w16_q;
    w32_d = serial_tx_pin_oe ? (oe_q ? w32_q : 3'h0) + 3'(baud_ref_clock_x32) : w32_q;
    lo_d = decoded_rx_stream ? 5'h0 : lo_q + 5'(lo_q != 5'h1f && baud_ref_clock_x16);
    sf_d = (pin_q && !serial_rx_pin) ? 5'h0 : sf_q + 5'(sf_q != 5'h1f && baud_ref_clock_x16);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      oe_q <= 1'b0;
      pin_q <= 1'b1;
      ir_q <= 3'h0;
      st_q <= 3'h0;
      w16_q <= 3'h0;
      w32_q <= 3'h0;
      lo_q <= 5'h0;
      sf_q <= 5'h1f;
    end else begin
      wr_q <= wr_d;
      oe_q <= serial_tx_pin_oe;
      pin_q <= serial_rx_pin;
      ir_q <= ir_d;
      st_q <= st_d;
      w16_q <= w16_d;
      w32_q <= w32_d;
      lo_q <= lo_d;
      sf_q <= sf_d;
    end
  end
  // Mode settled for seven cycles; switch-over transients excluded
  assign ir_on = st_q == 3'h7 && ir_q[0];
  assign ir_off = st_q == 3'h7 && !ir_q[0];
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pulse_end;
    $fell(serial_tx_pin_oe) ##1 1'b1;
  endsequence
  sequence s_rx_rise;
    ir_on ##0 $rose(decoded_rx_stream);
  endsequence
  property p_x16_gap;
    baud_ref_clock_x16 |=> !baud_ref_clock_x16;
  endproperty
  a_x16_gap: assert property (p_x16_gap) else $error("x16 ticks adjacent");
  property p_tx_pass;
    ir_off |-> serial_tx_pin_oe && serial_tx_pin_o == $past(sci_tx_stream);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx pin not passed");
  property p_rx_pass;
    ir_off |-> decoded_rx_stream == $past(serial_rx_pin, 3);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx pin not passed");
  property p_w316;
    (ir_on && ir_q[2] == ir_q[1]) ##0 s_pulse_end |-> w16_q inside {[2:3]};
  endproperty
  a_w316: assert property (p_w316) else $error("wide pulse length");
  property p_w116;
    (ir_on && ir_q[2:1] == 2'b01) ##0 s_pulse_end |-> w16_q <= 3'h1;
  endproperty
  a_w116: assert property (p_w116) else $error("sixteenth pulse length");
  property p_w132;
    (ir_on && ir_q[2:1] == 2'b10) ##0 s_pulse_end |-> w32_q <= 3'h1;
  endproperty
  a_w132: assert property (p_w132) else $error("x32 pulse length");
  property p_rx_hold;
    s_rx_rise |-> lo_q >= 5'd13;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("decoded low too short");
  property p_rx_end;
    ir_on && !decoded_rx_stream |-> sf_q <= 5'd17;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("decoded low too long");
endmodule : irc_codec_properties
bind irc_codec irc_codec_properties #(.ADDR_W(ADDR_W)) u_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .sci_tx_stream(sci_tx_stream),
  .decoded_rx_stream(decoded_rx_stream), .serial_tx_pin_o(serial_tx_pin_o),
  .serial_tx_pin_oe(serial_tx_pin_oe), .serial_rx_pin(serial_rx_pin),
  .baud_ref_clock_x16(baud_ref_clock_x16), .baud_ref_clock_x32(baud_ref_clock_x32));

// file: irc_ir_link.sv
`timescale 1ns/1ps
module irc_ir_link (
  input wire logic hclk,
  input wire logic tx_o,
  input wire logic tx_oe,
  output logic tx_line,
  output logic rx_pin
);
  int falls = 0;
  int gap = 0;
  int lown = 0;
  int cyc = 0;
  int last = 0;
  logic prev = 1'b1;
  // Pull-up holds the released open-drain line high
  assign tx_line = tx_oe ? tx_o : 1'b1;
  initial rx_pin = 1'b1;
  always @(negedge hclk) begin
    cyc++;
    if (tx_line === 1'b0 && prev) begin
      falls++;
      gap = cyc - last;
      last = cyc;
      lown = 0;
    end
    if (tx_line === 1'b0) lown++;
    prev = tx_line;
  end
  task automatic flash(input int n);
    @(posedge hclk);
    rx_pin <= 1'b0;
    repeat (n) @(posedge hclk);
    rx_pin <= 1'b1;
  endtask : flash
endmodule : irc_ir_link

// file: irc_codec_tb_top.sv
`timescale 1ns/1ps
module irc_codec_tb_top;
  import irc_pkg::*;
  localparam int LO[4] = '{9, 1, 1, 9};
  localparam int HI[4] = '{13, 5, 3, 13};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic stream = 1'b1;
  logic nine_ld = 1'b0;
  logic nine = 1'b0;
  logic dq = 1'b1;
  logic [7:0] st1 = 8'h5a;
  logic [7:0] rxd = 8'h3c;
  logic hready, hresp, tx_o, tx_oe, dec, x16, x32, rx_pin, tx_line;
  logic [31:0] hrdata;
  logic [7:0] tx_data;
  logic xtal = 1'b0;
  logic [1:0] st2 = 2'h2;
  logic [7:0] c1_o, c2_o, c3_o;
  logic tdl, rdt;
  int takes = 0;
  int errors = 0;
  int check_count = 0;
  int dfalls = 0;
  int run = 0;
  int dlen = 0;
  always #50 hclk = ~hclk;
  // Crystal reference, rising every 400 ns, off the bus clock rising edges
  always #200 xtal = ~xtal;
  irc_codec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .crystal_ref_clock(xtal), .sci_tx_stream(stream),
    .decoded_rx_stream(dec), .serial_tx_pin_o(tx_o), .serial_tx_pin_oe(tx_oe),
    .serial_rx_pin(rx_pin), .baud_ref_clock_x16(x16), .baud_ref_clock_x32(x32),
    .status_one_in(st1), .status_two_in(st2), .rx_data_in(rxd), .rx_ninth_load(nine_ld),
    .rx_ninth_in(nine), .serial_control_one(c1_o), .serial_control_two(c2_o),
    .serial_control_three(c3_o), .tx_data(tx_data), .tx_data_load(tdl),
    .rx_data_taken(rdt));
  irc_ir_link u_link (.hclk(hclk), .tx_o(tx_o), .tx_oe(tx_oe), .tx_line(tx_line),
    .rx_pin(rx_pin));
  always @(negedge hclk) begin
    if (dec === 1'b0 && dq) begin
      dfalls++;
      run = 0;
    end
    if (dec === 1'b0) run++;
    else if (!dq) dlen = run;
    if (rdt === 1'b1) takes++;
    dq = dec;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task check_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("MISMATCH %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_rng
  task wait_hi;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errors++;
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask : wait_hi
  task ahb(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {2'b00, idx, 2'b00};
    wait_hi;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_hi;
    r = hrdata;
  endtask : ahb
  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, idx, d, r);
  endtask : wr
  task rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, idx, 32'h0, r);
    check(r, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rd_chk
  task wait_dec(input logic v, input int m);
    int n;
    n = 0;
    @(negedge hclk);
    while (dec !== v) begin
      n++;
      if (n > m) begin
        errors++;
        end_of_test;
      end
      @(negedge hclk);
    end
  endtask : wait_dec
  // Counts edges up to the next one that sees a 16x tick
  task wait_x16(output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
      if (n > 100) begin
        errors++;
        end_of_test;
      end
    end while (x16 !== 1'b1);
  endtask : wait_x16
  task t_regs;
    wr(IDX_CTRL_ONE, 32'hff);
    wr(IDX_CTRL_TWO, 32'ha5);
    rd_chk(IDX_CTRL_ONE, 32'hdf);
    check({24'h0, c1_o}, 32'hdf);
    check({24'h0, c2_o}, 32'ha5);
    rd_chk(IDX_STATUS_ONE, 32'h5a);
    rd_chk(IDX_STATUS_TWO, 32'h2);
    rd_chk(IDX_DATA_BUF, 32'h3c);
    check(takes, 32'h1);
    rd_chk(8'h80, 32'h0);
    wr(IDX_BAUD_SEL, 32'hff);
    rd_chk(IDX_BAUD_SEL, 32'hb7);
    wr(IDX_DATA_BUF, 32'h96);
    @(negedge hclk);
    check({24'h0, tx_data}, 32'h96);
    check({31'h0, tdl}, 32'h1);
    @(posedge hclk);
    nine <= 1'b1;
    nine_ld <= 1'b1;
    @(posedge hclk);
    nine_ld <= 1'b0;
    wr(IDX_CTRL_THREE, 32'h7f);
    rd_chk(IDX_CTRL_THREE, 32'hff);
    check({24'h0, c3_o}, 32'hff);
    // Mid-run reset: ninth bits must survive it
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(IDX_CTRL_THREE, 32'hc0);
    check({24'h0, c3_o}, 32'hc0);
    rd_chk(IDX_CTRL_ONE, 32'h0);
    rd_chk(IDX_BAUD_SEL, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task t_src;
    int n;
    wait_x16(n);
    wait_x16(n);
    check_rng(n, 4, 4);
    wr(IDX_BAUD_SEL, 32'h80);
    // First tick after the switch may be irregular
    wait_x16(n);
    wait_x16(n);
    wait_x16(n);
    check_rng(n, 16, 16);
    $display("test baud source done");
  endtask : t_src
  task t_pass;
    int f;
    @(posedge hclk);
    stream <= 1'b0;
    repeat (5) @(posedge hclk);
    stream <= 1'b1;
    repeat (4) @(posedge hclk);
    check_rng(u_link.lown, 5, 5);
    f = dfalls;
    u_link.flash(6);
    repeat (6) @(posedge hclk);
    check_rng(dfalls - f, 1, 1);
    check_rng(dlen, 6, 6);
    $display("test passthrough done");
  endtask : t_pass
  task t_tx;
    int f;
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(IDX_IR_CTRL, 32'(c * 2 + 1));
      f = u_link.falls;
      // Core shifts its stream on a 16x tick
      wait_x16(n);
      stream <= 1'b0;
      repeat (120) @(posedge hclk);
      stream <= 1'b1;
      repeat (136) @(posedge hclk);
      check_rng(u_link.falls - f, 2, 2);
      check_rng(u_link.gap, 64, 64);
      check_rng(u_link.lown, LO[c], HI[c]);
    end
    $display("test encoder done");
  endtask : t_tx
  task t_rx;
    int f;
    wr(IDX_IR_CTRL, 32'h1);
    f = dfalls;
    u_link.flash(4);
    repeat (16) @(posedge hclk);
    u_link.flash(4);
    repeat (100) @(posedge hclk);
    check_rng(dfalls - f, 1, 1);
    check_rng(dlen, 54, 68);
    u_link.flash(4);
    repeat (40) @(posedge hclk);
    u_link.flash(4);
    repeat (140) @(posedge hclk);
    check_rng(dlen, 98, 112);
    f = dfalls;
    u_link.flash(4);
    wait_dec(1'b0, 8);
    wait_dec(1'b1, 200);
    u_link.flash(2);
    repeat (80) @(posedge hclk);
    check_rng(dfalls - f, 1, 1);
    $display("test decoder done");
  endtask : t_rx
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_src;
    // Bus clock 64 times the baud rate
    wr(IDX_BAUD_SEL, 32'h0);
    t_pass;
    t_tx;
    t_rx;
    end_of_test;
  end
endmodule : irc_codec_tb_top
